// ===== hw/opm_pkg.sv
// Constants and types of the operating-mode controller.
// Assumes one core clock; no software-reachable register bus.
package opm_pkg;

  typedef enum logic [2:0] {
    OPM_ST_COMPAT,
    OPM_ST_PROT,
    OPM_ST_SAVE,
    OPM_ST_HK,
    OPM_ST_RESTORE
  } opm_state_e;

  typedef enum logic [1:0] {
    OPM_MODE_COMPAT,
    OPM_MODE_PROT,
    OPM_MODE_HK
  } opm_mode_e;

  // Execution context layout
  localparam int         GPR_COUNT    = 8;
  localparam int         SEG_COUNT    = 6;
  localparam int         CTX_REGS     = 16;
  localparam int         CTX_AW       = 4;
  localparam int         CTX_DW       = 32;
  localparam logic [3:0] CTX_GPR_BASE = 4'h0;
  localparam logic [3:0] CTX_SEG_BASE = 4'h8;
  localparam logic [3:0] CTX_FLAGS    = 4'hE;
  localparam logic [3:0] CTX_IPTR     = 4'hF;
  localparam logic [3:0] CTX_LAST     = 4'hF;
  localparam logic [4:0] CTX_DONE     = 5'h10;

  // Address widths
  localparam int LIN_AW    = 32;
  localparam int PHYS_AW   = 36;
  localparam int PAGE_HI_W = PHYS_AW - LIN_AW;
  localparam int SEG_OFF_W = 16;
  localparam int SEL_W     = 16;
  localparam int REAL_AW   = 20;
  localparam int SEG_SHIFT = 4;

  // System control word
  localparam int CTL_W      = 8;
  localparam int CTL_PE_BIT = 0;
  localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;

  // Management memory window, base is a plain default
  localparam logic [PHYS_AW-1:0] MGMT_BASE_DEF = 36'h0_0003_0000;

endpackage

// ===== hw/opm_ctx_if.sv
// Save/restore port between the mode controller and its context store.
// Assumes both ends on the core clock.
`timescale 1ns/1ps
interface opm_ctx_if;
  import opm_pkg::*;
  logic              we;
  logic [CTX_AW-1:0] waddr;
  logic [CTX_DW-1:0] wdata;
  logic              re;
  logic [CTX_AW-1:0] raddr;
  logic [CTX_DW-1:0] rdata;

  modport ctl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

// ===== hw/opm_ctx_mem.sv
// Context store: one word per architectural register, registered read.
// Assumes the controller never reads and writes the same word at once.
`timescale 1ns/1ps
module opm_ctx_mem (
  // Clock
  input wire logic mclk_i,
  // Store port
  opm_ctx_if.mem   port
);
  import opm_pkg::*;

  logic [CTX_DW-1:0] store_r [CTX_REGS];

  always_ff @(posedge mclk_i) begin
    if (port.we) begin
      store_r[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (port.re) begin
      port.rdata <= store_r[port.raddr];
    end
  end
endmodule

// ===== hw/opm_ctrl.sv
// Operating-mode controller of the core: compatibility, protected, housekeeping.
// Assumes the register file answers ctx_rd_idx_o combinationally in the same cycle.
//
// Overview of operation
// R1: Reset always leaves the core in compatibility mode.
// R2: Exactly three modes exist and the mode gates which features software may use.
// R3: Protected mode opens every instruction and feature to software; feat_full_o drops for legacy tasks.
// R4: Legacy emulation is a per-task flag inside protected mode, not a mode of its own.
// R5: From compatibility mode software may move to protected or housekeeping mode.
// R6: A management pin assertion or interrupt-controller message enters housekeeping mode.
// R7: Entry saves the whole register context and moves to a private address space.
// R8: Return restores exactly the previous mode and register context.
// R9: Each task sees up to 4 GB linear space on a physical space of up to 64 GB.
// R10: The context is eight general, six segment, one flags and one pointer register.
// R11: The same execution resources exist in every mode.
// R12: A system control word selects the mode and describes the running task.
// R13: Compatibility mode addresses memory as segments of at most 64 KB.
// R14: Housekeeping mode steers accesses into the private management memory.
// R15: The mode changes only on reset, software switch, or housekeeping entry and exit.
// R16: Management interrupts are ignored from entry until the return completes.
`timescale 1ns/1ps
module opm_ctrl #(
  parameter logic [opm_pkg::PHYS_AW-1:0] MGMT_BASE = opm_pkg::MGMT_BASE_DEF
) (
  // Clock and reset
  input  wire logic                           mclk_i,
  input  wire logic                           rst_i,
  // Management interrupt sources
  input  wire logic                           mgmt_irq_n_i,
  input  wire logic                           mgmt_interrupt_i,
  // Software control
  input  wire logic                           ctl_wr_i,
  input  wire logic [opm_pkg::CTL_W-1:0]      ctl_wdata_i,
  input  wire logic                           sw_mgmt_req_i,
  input  wire logic                           mgmt_return_i,
  input  wire logic                           task_load_i,
  input  wire logic                           task_legacy_i,
  // Context save and restore
  input  wire logic [opm_pkg::CTX_DW-1:0]     arch_data_i,
  output logic      [opm_pkg::CTX_AW-1:0]     ctx_rd_idx_o,
  output logic                                ctx_restore_we_o,
  output logic      [opm_pkg::CTX_AW-1:0]     ctx_restore_idx_o,
  output logic      [opm_pkg::CTX_DW-1:0]     ctx_restore_data_o,
  // Address request
  input  wire logic                           addr_req_i,
  input  wire logic [opm_pkg::SEL_W-1:0]      seg_sel_i,
  input  wire logic [opm_pkg::LIN_AW-1:0]     offset_i,
  input  wire logic [opm_pkg::PAGE_HI_W-1:0]  page_hi_i,
  output logic                                addr_vld_o,
  output logic                                addr_fault_o,
  output logic                                addr_mgmt_o,
  output logic      [opm_pkg::PHYS_AW-1:0]    phys_addr_o,
  // Mode status
  output opm_pkg::opm_mode_e                  mode_o,
  output logic                                feat_full_o,
  output logic                                legacy_task_o,
  output logic                                ctx_busy_o,
  output logic      [opm_pkg::CTL_W-1:0]      ctl_o
);
  import opm_pkg::*;

  opm_state_e        state_r;
  opm_state_e        state_nxt;
  opm_state_e        saved_state_r;
  logic [CTL_W-1:0]  ctl_r;
  logic [CTL_W-1:0]  saved_ctl_r;
  logic              legacy_r;
  logic              saved_legacy_r;
  logic [4:0]        idx_r;
  logic              irq_meta_r;
  logic              irq_sync_r;
  logic              irq_prev_r;
  logic              pin_evt;
  logic              mgmt_req;
  logic              in_normal;
  logic              rd_pend_r;
  logic [CTX_AW-1:0] rd_idx_r;

  opm_ctx_if ctx ();

  opm_ctx_mem u_mem (
    .mclk_i (mclk_i),
    .port   (ctx.mem)
  );

  // Pin is asynchronous; only the second and third stages are looked at
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_meta_r <= 1'b1;
      irq_sync_r <= 1'b1;
      irq_prev_r <= 1'b1;
    end else begin
      irq_meta_r <= mgmt_irq_n_i;
      irq_sync_r <= irq_meta_r;
      irq_prev_r <= irq_sync_r;
    end
  end

  // Edge, not level, so a pin held low does not re-enter after return
  assign pin_evt   = irq_prev_r & ~irq_sync_r;
  assign in_normal = (state_r == OPM_ST_COMPAT) || (state_r == OPM_ST_PROT);
  // Requests outside the normal modes are dropped, not queued
  assign mgmt_req  = in_normal & (pin_evt | mgmt_interrupt_i | sw_mgmt_req_i); // [R6] [R16] [R5]

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      OPM_ST_COMPAT: begin
        if (mgmt_req) begin
          state_nxt = OPM_ST_SAVE; // [R5] [R6]
        end else if (ctl_wr_i && ctl_wdata_i[CTL_PE_BIT]) begin
          state_nxt = OPM_ST_PROT; // [R5] [R12]
        end
      end
      OPM_ST_PROT: begin
        if (mgmt_req) begin
          state_nxt = OPM_ST_SAVE; // [R6]
        end else if (ctl_wr_i && !ctl_wdata_i[CTL_PE_BIT]) begin
          state_nxt = OPM_ST_COMPAT; // [R12]
        end
      end
      OPM_ST_SAVE: begin
        if (idx_r[CTX_AW-1:0] == CTX_LAST) begin
          state_nxt = OPM_ST_HK; // [R7]
        end
      end
      OPM_ST_HK: begin
        if (mgmt_return_i) begin
          state_nxt = OPM_ST_RESTORE;
        end
      end
      OPM_ST_RESTORE: begin
        if (idx_r == CTX_DONE) begin
          state_nxt = saved_state_r; // [R8]
        end
      end
    endcase
  end

  // Mode register moves only through the transitions above
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= OPM_ST_COMPAT; // [R1] [R15]
    end else begin
      state_r <= state_nxt; // [R15]
    end
  end

  // Mode seen before entry, kept for the return
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      saved_state_r  <= OPM_ST_COMPAT;
      saved_ctl_r    <= CTL_RESET;
      saved_legacy_r <= 1'b0;
    end else if (mgmt_req) begin
      saved_state_r  <= state_r; // [R8]
      saved_ctl_r    <= ctl_r;
      saved_legacy_r <= legacy_r;
    end
  end

  // System control word; handler writes are undone on return
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctl_r <= CTL_RESET; // [R1]
    end else if (state_r == OPM_ST_RESTORE && idx_r == CTX_DONE) begin
      ctl_r <= saved_ctl_r; // [R8]
    end else if (ctl_wr_i && !mgmt_req) begin
      ctl_r <= ctl_wdata_i; // [R12]
    end
  end

  // Per-task legacy attribute, meaningful only in protected mode
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      legacy_r <= 1'b0;
    end else if (state_r == OPM_ST_RESTORE && idx_r == CTX_DONE) begin
      legacy_r <= saved_legacy_r; // [R8]
    end else if (task_load_i && state_r == OPM_ST_PROT) begin
      legacy_r <= task_legacy_i; // [R4]
    end else if (state_r == OPM_ST_COMPAT) begin
      legacy_r <= 1'b0; // [R4]
    end
  end

  // Walk index for both the save and the restore pass
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      idx_r <= '0;
    end else if (state_nxt != state_r) begin
      idx_r <= '0;
    end else if (state_r == OPM_ST_SAVE || state_r == OPM_ST_RESTORE) begin
      idx_r <= idx_r + 5'h01; // [R10]
    end
  end

  // Save: sixteen words, general, segment, flags, pointer, same in every mode
  assign ctx.we    = (state_r == OPM_ST_SAVE); // [R7] [R10] [R11]
  assign ctx.waddr = idx_r[CTX_AW-1:0];
  assign ctx.wdata = arch_data_i;
  // Restore: read issued two cycles ahead of the write-back
  assign ctx.re    = (state_r == OPM_ST_RESTORE) && (idx_r != CTX_DONE); // [R8]
  assign ctx.raddr = idx_r[CTX_AW-1:0];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_pend_r <= 1'b0;
      rd_idx_r  <= '0;
    end else begin
      rd_pend_r <= ctx.re;
      rd_idx_r  <= ctx.raddr;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctx_rd_idx_o       <= '0;
      ctx_restore_we_o   <= 1'b0;
      ctx_restore_idx_o  <= '0;
      ctx_restore_data_o <= '0;
    end else begin
      ctx_rd_idx_o       <= (state_nxt == OPM_ST_SAVE && state_r == OPM_ST_SAVE) ?
                            idx_r[CTX_AW-1:0] + 4'h1 : '0;
      ctx_restore_we_o   <= rd_pend_r; // [R8]
      ctx_restore_idx_o  <= rd_idx_r;
      // Store output is unknown before its first read; keep the port at zero then
      ctx_restore_data_o <= rd_pend_r ? ctx.rdata : '0;
    end
  end

  // Address formation per mode
  logic [REAL_AW-1:0] real_addr;
  logic [PHYS_AW-1:0] phys_nxt;
  logic               fault_nxt;
  logic               mgmt_nxt;

  // Segment base is selector times sixteen, wraps at the real-mode limit
  assign real_addr = {seg_sel_i, {SEG_SHIFT{1'b0}}} + {{SEG_SHIFT{1'b0}}, offset_i[SEG_OFF_W-1:0]};

  always_comb begin
    phys_nxt  = '0;
    fault_nxt = 1'b0;
    mgmt_nxt  = 1'b0;
    unique case (state_r)
      OPM_ST_COMPAT: begin
        phys_nxt  = {{(PHYS_AW-REAL_AW){1'b0}}, real_addr};
        fault_nxt = |offset_i[LIN_AW-1:SEG_OFF_W]; // [R13]
      end
      OPM_ST_PROT: begin
        if (legacy_r) begin
          phys_nxt  = {{(PHYS_AW-REAL_AW){1'b0}}, real_addr}; // [R4]
          fault_nxt = |offset_i[LIN_AW-1:SEG_OFF_W];
        end else begin
          phys_nxt = {page_hi_i, offset_i}; // [R9]
        end
      end
      OPM_ST_HK: begin
        // Private window, real-style offsets above its base
        phys_nxt  = MGMT_BASE + {{(PHYS_AW-REAL_AW){1'b0}}, real_addr}; // [R14]
        mgmt_nxt  = 1'b1; // [R14]
        fault_nxt = |offset_i[LIN_AW-1:SEG_OFF_W];
      end
      OPM_ST_SAVE, OPM_ST_RESTORE: begin
        // Context moves in flight; no program access is served
        fault_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      addr_vld_o   <= 1'b0;
      addr_fault_o <= 1'b0;
      addr_mgmt_o  <= 1'b0;
      phys_addr_o  <= '0;
    end else begin
      addr_vld_o   <= addr_req_i;
      addr_fault_o <= addr_req_i & fault_nxt;
      addr_mgmt_o  <= addr_req_i & mgmt_nxt;
      phys_addr_o  <= addr_req_i ? phys_nxt : '0;
    end
  end

  // Mode, feature and busy outputs follow the next state so they line up with state_r; ctl_o trails ctl_r by a cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_o        <= OPM_MODE_COMPAT; // [R1]
      feat_full_o   <= 1'b0;
      legacy_task_o <= 1'b0;
      ctx_busy_o    <= 1'b0;
      ctl_o         <= CTL_RESET;
    end else begin
      unique case (state_nxt)
        OPM_ST_COMPAT: mode_o <= OPM_MODE_COMPAT; // [R2]
        OPM_ST_PROT:   mode_o <= OPM_MODE_PROT;
        default:       mode_o <= OPM_MODE_HK;
      endcase
      feat_full_o   <= (state_nxt == OPM_ST_PROT) && !legacy_r; // [R3] [R2]
      legacy_task_o <= (state_nxt == OPM_ST_PROT) && legacy_r; // [R4]
      ctx_busy_o    <= (state_nxt == OPM_ST_SAVE) || (state_nxt == OPM_ST_RESTORE);
      ctl_o         <= ctl_r; // [R12]
    end
  end
endmodule

// ===== tb/opm_ctrl_props.sv
// Port checks of the operating-mode controller.
// Assumes binding onto opm_ctrl, one clock, synchronous reset.
`timescale 1ns/1ps
module opm_ctrl_props
  import opm_pkg::*;
#(
  parameter logic [PHYS_AW-1:0] MGMT_BASE = MGMT_BASE_DEF
) (
  // Clock, reset and requests
  input wire logic                 mclk_i,
  input wire logic                 rst_i,
  input wire logic                 mgmt_interrupt_i,
  input wire logic                 sw_mgmt_req_i,
  input wire logic                 mgmt_return_i,
  input wire logic                 ctl_wr_i,
  input wire logic [CTL_W-1:0]     ctl_wdata_i,
  input wire logic                 addr_req_i,
  input wire logic [SEL_W-1:0]     seg_sel_i,
  input wire logic [LIN_AW-1:0]    offset_i,
  input wire logic [PAGE_HI_W-1:0] page_hi_i,
  // Observed outputs
  input wire logic                 ctx_restore_we_o,
  input wire logic [CTX_AW-1:0]    ctx_restore_idx_o,
  input wire logic [CTX_AW-1:0]    ctx_rd_idx_o,
  input wire logic                 addr_vld_o,
  input wire logic                 addr_fault_o,
  input wire logic                 addr_mgmt_o,
  input wire logic [PHYS_AW-1:0]   phys_addr_o,
  input wire opm_mode_e            mode_o,
  input wire logic                 feat_full_o,
  input wire logic                 legacy_task_o,
  input wire logic                 ctx_busy_o,
  input wire logic [CTL_W-1:0]     ctl_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic               quiet;
  logic [REAL_AW-1:0] real_a;
  logic [PHYS_AW-1:0] flat_a;
  // No control write, message or software entry can land on the same edge; a pin edge is not excluded
  assign quiet  = !mgmt_interrupt_i && !sw_mgmt_req_i && !ctl_wr_i;
  assign real_a = {seg_sel_i, 4'h0} + {4'h0, offset_i[15:0]};
  assign flat_a = {page_hi_i, offset_i};

  property p_reset; $fell(rst_i) |-> mode_o == OPM_MODE_COMPAT && ctl_o == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("not compat after reset");
  property p_modes; mode_o != 2'h3; endproperty
  a_modes: assert property (p_modes) else $error("illegal mode");
  property p_to_prot;
    mode_o == OPM_MODE_COMPAT && ctl_wr_i && ctl_wdata_i[CTL_PE_BIT] && !mgmt_interrupt_i
      && !sw_mgmt_req_i |=> mode_o == OPM_MODE_PROT ##1 ctl_o == $past(ctl_wdata_i, 2);
  endproperty
  a_to_prot: assert property (p_to_prot) else $error("no switch to protected");
  property p_entry;
    mode_o != OPM_MODE_HK && (mgmt_interrupt_i || sw_mgmt_req_i)
      |=> mode_o == OPM_MODE_HK && ctx_busy_o && ctx_rd_idx_o == 4'h0;
  endproperty
  a_entry: assert property (p_entry) else $error("no entry");
  property p_save_len;
    $rose(ctx_busy_o) && $past(mode_o) != OPM_MODE_HK
      |-> ##15 (ctx_busy_o && ctx_rd_idx_o == CTX_LAST) ##1 !ctx_busy_o;
  endproperty
  a_save_len: assert property (p_save_len) else $error("save pass length");
  property p_restore;
    $rose(ctx_restore_we_o) |-> ctx_restore_idx_o == 4'h0 ##15
      (ctx_restore_we_o && ctx_restore_idx_o == CTX_LAST) ##1
      (!ctx_restore_we_o && mode_o != OPM_MODE_HK);
  endproperty
  a_restore: assert property (p_restore) else $error("restore pass");
  property p_hk_deaf;
    mode_o == OPM_MODE_HK && !ctx_busy_o && !mgmt_return_i
      && (mgmt_interrupt_i || sw_mgmt_req_i) |=> mode_o == OPM_MODE_HK && !ctx_busy_o;
  endproperty
  a_hk_deaf: assert property (p_hk_deaf) else $error("entry taken twice");
  property p_real_addr;
    (mode_o == OPM_MODE_COMPAT || legacy_task_o) && addr_req_i && quiet
      && offset_i[31:16] == 16'h0000 |=> addr_vld_o && !addr_fault_o && !addr_mgmt_o
      && phys_addr_o == {16'h0000, $past(real_a)};
  endproperty
  a_real_addr: assert property (p_real_addr) else $error("segment address");
  property p_fault;
    (mode_o == OPM_MODE_COMPAT || legacy_task_o) && addr_req_i && quiet
      && offset_i[31:16] != 16'h0000 |=> addr_vld_o && addr_fault_o;
  endproperty
  a_fault: assert property (p_fault) else $error("no segment limit fault");
  property p_prot_addr;
    mode_o == OPM_MODE_PROT && !legacy_task_o && addr_req_i && quiet
      |=> !addr_fault_o && phys_addr_o == $past(flat_a);
  endproperty
  a_prot_addr: assert property (p_prot_addr) else $error("flat address");
  property p_hk_addr;
    mode_o == OPM_MODE_HK && !ctx_busy_o && addr_req_i && !mgmt_return_i
      && offset_i[31:16] == 16'h0000 |=> addr_mgmt_o && phys_addr_o == MGMT_BASE + $past(real_a);
  endproperty
  a_hk_addr: assert property (p_hk_addr) else $error("private memory address");
  property p_busy_addr; ctx_busy_o && addr_req_i |=> addr_vld_o && addr_fault_o; endproperty
  a_busy_addr: assert property (p_busy_addr) else $error("address during pass");
  property p_feat; feat_full_o |-> mode_o == OPM_MODE_PROT && !legacy_task_o; endproperty
  a_feat: assert property (p_feat) else $error("features outside protected");
endmodule

bind opm_ctrl opm_ctrl_props #(.MGMT_BASE(MGMT_BASE)) i_props (.*);

// ===== tb/opm_plat_model.sv
// Platform side: register file answering the save index, plus the
// management pin and interrupt-controller message. Bench calls tasks after an edge.
`timescale 1ns/1ps
module opm_plat_model
  import opm_pkg::*;
(
  // Clock
  input  wire logic              mclk_i,
  // Register file read
  input  wire logic [CTX_AW-1:0] rd_idx_i,
  output logic      [CTX_DW-1:0] arch_data_o,
  // Management sources
  output logic                   mgmt_irq_n_o,
  output logic                   mgmt_interrupt_o
);
  logic [CTX_DW-1:0] regs [CTX_REGS];
  // Eight general, six segment, flags and pointer words
  assign arch_data_o = regs[rd_idx_i];
  initial begin
    mgmt_irq_n_o = 1'b1;
    mgmt_interrupt_o = 1'b0;
    foreach (regs[i]) regs[i] = 32'h0;
  end
  // Slow platforms hold the pin low several cycles
  task automatic fire_pin(input int hold);
    mgmt_irq_n_o = 1'b0;
    repeat (hold) @(posedge mclk_i);
    #1 mgmt_irq_n_o = 1'b1;
  endtask
  task automatic fire_msg();
    mgmt_interrupt_o = 1'b1;
    @(posedge mclk_i);
    #1 mgmt_interrupt_o = 1'b0;
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench of the operating-mode controller.
// Assumes opm_ctrl on top with the platform model on its far side.
`timescale 1ns/1ps
module tb;
  import opm_pkg::*;
  typedef struct packed {logic f; logic m; logic [PHYS_AW-1:0] p;} opm_exp_s;
  logic mclk_i = 1'b0, rst_i = 1'b1, ctl_wr_i = 1'b0, sw_mgmt_req_i = 1'b0;
  logic mgmt_return_i = 1'b0, task_load_i = 1'b0, task_legacy_i = 1'b0, addr_req_i = 1'b0;
  logic [CTL_W-1:0] ctl_wdata_i = 8'h00, ctl_o, pc;
  logic [SEL_W-1:0] seg_sel_i = 16'h0000;
  logic [LIN_AW-1:0] offset_i = 32'h0;
  logic [PAGE_HI_W-1:0] page_hi_i = 4'h0;
  logic mgmt_irq_n_i, mgmt_interrupt_i, ctx_restore_we_o, addr_vld_o, addr_fault_o;
  logic addr_mgmt_o, feat_full_o, legacy_task_o, ctx_busy_o;
  logic [CTX_DW-1:0] arch_data_i, ctx_restore_data_o, rnd = 32'hBEB45AAC;
  logic [CTX_AW-1:0] ctx_rd_idx_o, ctx_restore_idx_o;
  logic [PHYS_AW-1:0] phys_addr_o;
  opm_mode_e mode_o, pm;
  opm_exp_s expq[$], got_e;
  logic [CTX_DW-1:0] sav [CTX_REGS];
  int fails = 0, total_checks = 0, cyc = 0, rcnt = 0;

  opm_ctrl i_dut (.*);
  opm_plat_model i_plat (.mclk_i(mclk_i), .rd_idx_i(ctx_rd_idx_o), .arch_data_o(arch_data_i),
    .mgmt_irq_n_o(mgmt_irq_n_i), .mgmt_interrupt_o(mgmt_interrupt_i));

  always #5 mclk_i = ~mclk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [19:0] ra(input logic [15:0] s, input logic [15:0] o);
    return {s, 4'h0} + {4'h0, o};
  endfunction
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // Request stays up across calls; the caller drops it
  task automatic addr(input logic [15:0] s, input logic [31:0] o, input logic [3:0] h,
                      input opm_exp_s e);
    addr_req_i = 1'b1;
    seg_sel_i = s;
    offset_i = o;
    page_hi_i = h;
    expq.push_back(e);
    tick();
  endtask
  task automatic ctl(input logic [7:0] w);
    ctl_wr_i = 1'b1;
    ctl_wdata_i = w;
    tick();
    ctl_wr_i = 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(negedge mclk_i) begin
    if (addr_vld_o === 1'b1) begin
      if (expq.size() == 0) begin
        chk(1'b1, 1'b0, "address without request");
      end else begin
        got_e = expq.pop_front();
        chk({addr_fault_o, addr_mgmt_o}, {got_e.f, got_e.m}, "address flags");
        if (!got_e.f) chk(phys_addr_o, got_e.p, "physical address");
      end
    end
    if (ctx_restore_we_o === 1'b1) begin
      chk(ctx_restore_idx_o, rcnt, "restore order");
      chk(ctx_restore_data_o, sav[rcnt[3:0]], "restore data");
      rcnt++;
    end
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc > 3000) begin
      chk(1'b1, 1'b0, "timeout");
      stop_test();
    end
  end

  initial begin
    repeat (10) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    chk({mode_o, ctl_o}, {OPM_MODE_COMPAT, 8'h00}, "reset state");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      addr(rnd[15:0], {16'h0, rnd[31:16]}, rnd[3:0],
           '{1'b0, 1'b0, ra(rnd[15:0], rnd[31:16])});
    end
    addr(16'hFFFF, 32'h0000_FFFF, 4'h0, '{1'b0, 1'b0, ra(16'hFFFF, 16'hFFFF)});
    addr(16'h0001, 32'h0001_0000, 4'h0, '{1'b1, 1'b0, 36'h0});
    addr_req_i = 1'b0;
    $display("test compat addressing done");
    ctl(8'h01);
    chk({mode_o, feat_full_o}, {OPM_MODE_PROT, 1'b1}, "protected mode");
    rnd = lfsr(rnd);
    addr(rnd[15:0], rnd, rnd[7:4], '{1'b0, 1'b0, {rnd[7:4], rnd}});
    addr_req_i = 1'b0;
    task_load_i = 1'b1;
    task_legacy_i = 1'b1;
    tick();
    task_load_i = 1'b0;
    // Status ports follow the loaded flag one cycle later
    tick();
    chk({legacy_task_o, feat_full_o, mode_o}, {2'b10, OPM_MODE_PROT}, "legacy task");
    addr(16'h1234, 32'h0000_0056, 4'hF, '{1'b0, 1'b0, ra(16'h1234, 16'h0056)});
    addr_req_i = 1'b0;
    task_load_i = 1'b1;
    task_legacy_i = 1'b0;
    tick();
    task_load_i = 1'b0;
    tick();
    chk({legacy_task_o, feat_full_o}, 2'b01, "native task");
    $display("test protected done");
    for (int s = 0; s < 3; s++) begin
      pm = (s == 1) ? OPM_MODE_PROT : OPM_MODE_COMPAT;
      pc = (s == 1) ? 8'h01 : 8'h00;
      ctl(pc);
      foreach (sav[i]) begin
        rnd = lfsr(rnd);
        sav[i] = rnd;
        i_plat.regs[i] = rnd;
      end
      rcnt = 0;
      if (s == 0) i_plat.fire_pin(6);
      else if (s == 1) i_plat.fire_msg();
      else begin
        sw_mgmt_req_i = 1'b1;
        tick();
        sw_mgmt_req_i = 1'b0;
      end
      addr(16'h0002, 32'h0, 4'h0, '{1'b1, 1'b0, 36'h0});
      addr_req_i = 1'b0;
      chk(mode_o, OPM_MODE_HK, "entry");
      for (int k = 0; k < 40 && ctx_busy_o !== 1'b0; k++) tick();
      // Released file no longer holds the saved words
      foreach (sav[i]) i_plat.regs[i] = ~sav[i];
      i_plat.fire_msg();
      sw_mgmt_req_i = 1'b1;
      tick();
      sw_mgmt_req_i = 1'b0;
      chk({mode_o, ctx_busy_o}, {OPM_MODE_HK, 1'b0}, "second entry");
      addr(16'h0010, 32'h4, 4'h0, '{1'b0, 1'b1, MGMT_BASE_DEF + ra(16'h0010, 16'h0004)});
      addr_req_i = 1'b0;
      ctl(8'h5A);
      mgmt_return_i = 1'b1;
      tick();
      mgmt_return_i = 1'b0;
      for (int k = 0; k < 30 && mode_o === OPM_MODE_HK; k++) tick();
      tick();
      chk({mode_o, ctl_o}, {pm, pc}, "mode after return");
      chk(rcnt, 16, "restored words");
      $display("test entry source %0d done", s);
    end
    ctl(8'h01);
    rst_i = 1'b1;
    tick();
    tick();
    rst_i = 1'b0;
    chk({mode_o, ctl_o, feat_full_o}, {OPM_MODE_COMPAT, 8'h00, 1'b0}, "mid reset");
    tick();
    chk(expq.size(), 0, "missing address answers");
    $display("test mid reset done");
    stop_test();
  end
endmodule
